// ===== hdl/sbpa_arbiter.sv
// System bus arbiter: fixed priority with core boost, or round-robin
`timescale 1ns/1ps
module sbpa_arbiter
  import sbpa_pkg::*;
#(
  parameter int unsigned N = NUM_MASTERS
)
(
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // Master requests, bit order as in the package
  input  wire logic [N-1:0] i_req,
  // Core interrupt level, unmasked
  input  wire logic         i_core_irq,
  // Control word write strobe and data
  input  wire logic         i_ctrl_wr,
  input  wire logic [2:0]   i_ctrl_wdata,
  // Grants
  output logic      [N-1:0] o_grant,
  // Control readback
  output logic              o_priority_mode_select,
  output logic              o_irq_priority_boost_enable,
  output logic              o_irq_priority_boost_active
);
  // Elaboration check: the priority order is wired for seven masters
  if (N != NUM_MASTERS)
  begin : g_bad_count
    $error("sbpa_arbiter serves exactly seven masters");
  end

  localparam int unsigned IW = $clog2(N);

  sbpa_state_type  state;
  logic [N-1:0]    next_grant;
  logic [IW-1:0]   rr_start;
  logic [IW-1:0]   fixed_start;
  logic [IW-1:0]   pick_start;
  logic [N-1:0]    pick_onehot;
  logic            pick_any;
  logic            boosted;
  logic            held;

  // Mode and enable bits, software owned
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_priority_mode_select      <= RST_MODE_SEL;
      o_irq_priority_boost_enable <= RST_BOOST_EN;
    end
    else if (i_ctrl_wr)
    begin
      o_priority_mode_select      <= i_ctrl_wdata[BIT_MODE_SEL];
      o_irq_priority_boost_enable <= i_ctrl_wdata[BIT_BOOST_EN];
    end
  end

  // Active flag: interrupt sets while boost is enabled, write of 0 clears; set wins over clear
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_irq_priority_boost_active <= RST_BOOST_ACT;
    else if (o_irq_priority_boost_enable && i_core_irq)
      o_irq_priority_boost_active <= 1'b1;
    else if (i_ctrl_wr && !i_ctrl_wdata[BIT_BOOST_ACT])
      o_irq_priority_boost_active <= 1'b0;
  end

  // Boost counts only in fixed mode with both bits set
  assign boosted = !o_priority_mode_select && o_irq_priority_boost_enable
                   && o_irq_priority_boost_active;

  // Core is last in the index order, so starting the scan at the core
  // puts it first and shifts the others down by one without reordering
  assign fixed_start = boosted ? IW'(IDX_CORE) : IW'(IDX_AUDIO);
  assign pick_start  = o_priority_mode_select ? rr_start : fixed_start;

  sbpa_pick #(
    .N (N)
  ) u_pick (
    .i_req    (i_req),
    .i_start  (pick_start),
    .o_onehot (pick_onehot),
    .o_any    (pick_any)
  );

  assign held = |(o_grant & i_req);

  // Hold the grant while the owner requests, else pick afresh
  always_comb
  begin
    if (state == SBPA_OWNED && held)
      next_grant = o_grant;
    else if (state == SBPA_OWNED)
      next_grant = '0;     // One idle cycle between owners keeps handover clean
    else
      next_grant = pick_any ? pick_onehot : '0;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_grant <= '0;
      state   <= SBPA_IDLE;
    end
    else
    begin
      o_grant <= next_grant;
      state   <= (|next_grant) ? SBPA_OWNED : SBPA_IDLE;
    end
  end

  // Round-robin pointer moves past each new owner
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      rr_start <= '0;
    else if (state == SBPA_IDLE && pick_any)
    begin
      for (int unsigned k = 0; k < N; k++)
        if (pick_onehot[k])
          rr_start <= (k == N - 1) ? '0 : IW'(k + 1);
    end
  end

  // Checks
  sequence s_owner_holds;
    state == SBPA_OWNED && held;
  endsequence

  a_grant_onehot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $onehot0(o_grant)) else $error("more than one grant");

  a_grant_held: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_owner_holds |=> o_grant == $past(o_grant)) else $error("grant moved while held");

  a_grant_needs_req: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state == SBPA_IDLE && i_req == '0 |=> o_grant == '0) else $error("grant without request");

  a_fixed_audio_wins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state == SBPA_IDLE && !o_priority_mode_select && i_req[IDX_AUDIO] && !boosted
    |=> o_grant[IDX_AUDIO]) else $error("audio lost in fixed mode");

  a_core_lowest: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state == SBPA_IDLE && !o_priority_mode_select && !boosted && (i_req[N-2:0] != '0)
    |=> !o_grant[IDX_CORE]) else $error("core won while lowest");

  a_core_boosted: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state == SBPA_IDLE && boosted && i_req[IDX_CORE]
    |=> o_grant[IDX_CORE]) else $error("boosted core lost");

  a_boost_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_irq_priority_boost_enable && i_core_irq |=> o_irq_priority_boost_active)
    else $error("boost flag not set");

  a_boost_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ctrl_wr && !i_ctrl_wdata[BIT_BOOST_ACT] && !(o_irq_priority_boost_enable && i_core_irq)
    |=> !o_irq_priority_boost_active) else $error("boost flag not cleared");

  a_boost_stay: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !o_irq_priority_boost_enable ##1 !o_irq_priority_boost_enable
    |-> !$rose(o_irq_priority_boost_active)) else $error("boost flag set while disabled");

  a_rr_rotates: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state == SBPA_IDLE && o_priority_mode_select && $countones(i_req) > 1
    |=> rr_start != $past(rr_start)) else $error("round-robin pointer stuck");

  // Handover steps: owner lets go, bus stays empty one cycle, then a pick
  sequence s_owner_leaves;
    state == SBPA_OWNED && !held;
  endsequence

  sequence s_idle_request;
    state == SBPA_IDLE && i_req != '0;
  endsequence

  sequence s_bus_empty;
    o_grant == '0 && state == SBPA_IDLE;
  endsequence

  a_handover_gap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_owner_leaves |=> s_bus_empty) else $error("no idle cycle after release");

  a_idle_answers: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_idle_request |=> o_grant != '0) else $error("request left unanswered");

  a_grant_to_req: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_grant & ~$past(i_req)) == '0) else $error("grant to a non-requester");

  a_no_switch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_grant != '0 |=> o_grant == '0 || o_grant == $past(o_grant))
    else $error("grant switched owners directly");

  a_mode_written: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ctrl_wr |=> o_priority_mode_select == $past(i_ctrl_wdata[BIT_MODE_SEL]))
    else $error("mode bit not written");

  a_enable_written: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ctrl_wr |=> o_irq_priority_boost_enable == $past(i_ctrl_wdata[BIT_BOOST_EN]))
    else $error("boost enable not written");

  a_boost_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_ctrl_wr && !(o_irq_priority_boost_enable && i_core_irq)
    |=> $stable(o_irq_priority_boost_active)) else $error("boost flag moved by itself");

  // The master at the pointer must win, boost bits play no part
  a_rr_pointer_wins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state == SBPA_IDLE && o_priority_mode_select && i_req[rr_start]
    |=> o_grant[$past(rr_start)]) else $error("round-robin skipped the pointer");
endmodule : sbpa_arbiter

// ===== hdl/sbpa_pkg.sv
// Shared constants for the system bus priority arbiter
package sbpa_pkg;
  // Master count and request/grant bit positions, highest fixed priority first
  localparam int unsigned NUM_MASTERS    = 7;
  localparam int unsigned IDX_AUDIO      = 0;
  localparam int unsigned IDX_GDMA0      = 1;
  localparam int unsigned IDX_GDMA1      = 2;
  localparam int unsigned IDX_ETH_DMA    = 3;
  localparam int unsigned IDX_USB_HOST   = 4;
  localparam int unsigned IDX_USB_DEV    = 5;
  localparam int unsigned IDX_CORE       = 6;
  // Control bit reset values
  localparam logic        RST_MODE_SEL   = 1'h0;
  localparam logic        RST_BOOST_EN   = 1'h0;
  localparam logic        RST_BOOST_ACT  = 1'h0;
  // Control bit positions in the arbitration control word
  localparam int unsigned BIT_MODE_SEL   = 0;
  localparam int unsigned BIT_BOOST_EN   = 1;
  localparam int unsigned BIT_BOOST_ACT  = 2;
  // Arbiter states
  typedef enum logic [0:0] {SBPA_IDLE, SBPA_OWNED} sbpa_state_type;
endpackage : sbpa_pkg

// ===== hdl/sbpa_pick.sv
// Combinational winner picker: first request at or after a start position
`timescale 1ns/1ps
module sbpa_pick
  import sbpa_pkg::*;
#(
  parameter int unsigned N = NUM_MASTERS
)
(
  // Requests and search start
  input  wire logic [N-1:0]         i_req,
  input  wire logic [$clog2(N)-1:0] i_start,
  // Result
  output logic      [N-1:0]         o_onehot,
  output logic                      o_any
);
  // Elaboration check: a wrapping scan needs at least two slots
  if (N < 2)
  begin : g_bad_count
    $error("sbpa_pick needs at least two masters");
  end

  // Scan from the start position, wrapping; only the first hit wins
  always_comb
  begin
    int unsigned idx;
    idx      = 0;
    o_onehot = '0;
    o_any    = 1'b0;
    for (int unsigned k = 0; k < N; k++)
    begin
      idx = (int'(i_start) + k) % N;
      if (!o_any && i_req[idx])
      begin
        o_onehot[idx] = 1'b1;
        o_any         = 1'b1;
      end
    end
  end
endmodule : sbpa_pick

// ===== verification/sbpa_masters.sv
// Behavioural bus masters that request, hold the grant a while, then retract
`timescale 1ns/1ps
module sbpa_masters
  import sbpa_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // Grant from the arbiter and new requests from the bench
  input  wire logic [6:0] i_grant,
  input  wire logic       i_load,
  input  wire logic [6:0] i_load_req,
  input  wire logic [3:0] i_hold,
  // Requests to the arbiter
  output logic      [6:0] o_req
);
  logic [3:0] cnt;
  // Owner keeps its request for i_hold extra cycles, then lets go
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_req <= 7'h00;
      cnt   <= 4'h0;
    end
    else if (|(i_grant & o_req) && cnt == i_hold)
    begin
      o_req <= (o_req | ({7{i_load}} & i_load_req)) & ~i_grant;
      cnt   <= 4'h0;
    end
    else
    begin
      o_req <= o_req | ({7{i_load}} & i_load_req);
      cnt   <= (|(i_grant & o_req)) ? cnt + 4'h1 : cnt;
    end
  end
endmodule : sbpa_masters

// ===== verification/sbpa_arbiter_test.sv
// Self-checking bench for the system bus arbiter
`timescale 1ns/1ps
module sbpa_arbiter_test;
  import sbpa_pkg::*;
  logic       clk = 0, rst = 1, irq = 0, wr = 0, load = 0;
  logic [2:0] wd = 3'h0;
  logic [3:0] hold = 4'h0;
  logic [6:0] req, grant, prev = 7'h00, preq = 7'h00, ld = 7'h00, rm = 7'h00;
  logic       ms, be, ba;
  logic [6:0] q[$];
  int         mismatches = 0, n_compared = 0, i;
  int         seed = 32'hEE50538F;
  always #5 clk = ~clk;
  sbpa_arbiter dut (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_core_irq(irq),
    .i_ctrl_wr(wr), .i_ctrl_wdata(wd), .o_grant(grant), .o_priority_mode_select(ms),
    .o_irq_priority_boost_enable(be), .o_irq_priority_boost_active(ba));
  sbpa_masters bus (.i_clk_sys(clk), .i_rst(rst), .i_grant(grant), .i_load(load),
    .i_load_req(ld), .i_hold(hold), .o_req(req));
  task chk(input logic [6:0] got, input logic [6:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Control write, readback valid on return
  task wctl(input logic [2:0] d);
    @(posedge clk);
    #1 wr = 1;
    wd = d;
    @(posedge clk);
    #1 wr = 0;
  endtask : wctl
  // Load requests with a random hold, wait until all owners are served
  task run(input logic [6:0] m);
    int k;
    @(posedge clk);
    #1 hold = 4'($unsigned($random(seed)) % 8);
    load = 1;
    ld = m;
    @(posedge clk);
    #1 load = 0;
    for (k = 0; k < 300; k++)
    begin
      @(posedge clk);
      if (req == 7'h00 && grant == 7'h00 && q.size() == 0)
        break;
    end
    #1;
    chk(7'(q.size()), 7'h00);
    chk(req | grant, 7'h00);
  endtask : run
  // Grant watcher: pre-edge values, so registered outputs are settled
  always @(posedge clk)
  begin
    if (!rst)
    begin
      if (!$onehot0(grant))
        chk(grant, 7'h00);
      if ((prev & preq) != 7'h00)
        chk(grant, prev);
      if (grant != 7'h00 && prev == 7'h00)
        chk(grant, (q.size() > 0) ? q.pop_front() : 7'h00);
      prev = grant;
      preq = req;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    chk({4'h0, ms, be, ba}, 7'h00);
    // Fixed order, all contending at once
    for (i = 0; i < 7; i++) q.push_back(7'h01 << i);
    run(7'h7F);
    // Random subset in fixed mode, still served lowest index first
    rm = 7'($unsigned($random(seed))) | 7'h08;
    for (i = 0; i < 7; i++)
      if (rm[i]) q.push_back(7'h01 << i);
    run(rm);
    // Boost: core first, rest shifted down
    wctl(3'b010);
    chk({6'h0, be}, 7'h01);
    irq = 1;
    repeat (2) @(posedge clk);
    chk({6'h0, ba}, 7'h01);
    q.push_back(7'h40);
    for (i = 0; i < 6; i++) q.push_back(7'h01 << i);
    run(7'h7F);
    irq = 0;
    wctl(3'b110);
    chk({6'h0, ba}, 7'h01);
    wctl(3'b010);
    chk({6'h0, ba}, 7'h00);
    wctl(3'b110);
    chk({6'h0, ba}, 7'h00);
    // Boost disabled, interrupt ignored, no clearing step needed
    wctl(3'b000);
    chk({6'h0, be}, 7'h00);
    irq = 1;
    for (i = 0; i < 7; i++) q.push_back(7'h01 << i);
    run(7'h7F);
    chk({6'h0, ba}, 7'h00);
    // Rotating with boost bits set: they must not matter
    wctl(3'b011);
    chk({6'h0, ms}, 7'h01);
    q.push_back(7'h04);
    run(7'h04);
    for (i = 0; i < 7; i++) q.push_back(7'h01 << ((i + 3) % 7));
    run(7'h7F);
    wrap_up();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule : sbpa_arbiter_test
